// >>> rtl/ctb_defs.svh
// constants of the core time base and timers block
`ifndef CTB_DEFS_SVH
`define CTB_DEFS_SVH

// ============================================================
// register byte offsets
`define CTB_OFF_CTRL   12'h000
`define CTB_OFF_TB_LO  12'h004
`define CTB_OFF_TB_HI  12'h008
`define CTB_OFF_RIT    12'h00C
`define CTB_OFF_STAT   12'h010
`define CTB_OFF_CLR    12'h014
`define CTB_OFF_IEN    12'h018

// ============================================================
// control register fields
`define CTB_CTRL_EXT     0
`define CTB_CTRL_AUTO    1
`define CTB_CTRL_FSEL_LO 2
`define CTB_CTRL_FSEL_HI 3
`define CTB_CTRL_WSEL_LO 4
`define CTB_CTRL_WSEL_HI 5
`define CTB_CTRL_RTYP_LO 6
`define CTB_CTRL_RTYP_HI 7
`define CTB_CTRL_WEN     8

// ============================================================
// status, clear and enable bit positions
`define CTB_EV_RIT  0
`define CTB_EV_PTT  1
`define CTB_EV_WD   2

// ============================================================
// time base bits watched by the tick timer and the watchdog
`define CTB_PTT_BIT0 9
`define CTB_PTT_BIT1 13
`define CTB_PTT_BIT2 17
`define CTB_PTT_BIT3 21
`define CTB_WD_BIT0  17
`define CTB_WD_BIT1  21
`define CTB_WD_BIT2  25
`define CTB_WD_BIT3  29

// ============================================================
// reset values and the constant one
`define CTB_RST_TB    64'h0000_0000_0000_0000
`define CTB_RST_W32   32'h0000_0000
`define CTB_RST_EV    3'h0
`define CTB_RST_SEL   2'h0
`define CTB_TB_ONE    64'h0000_0000_0000_0001
`define CTB_W32_ONE   32'h0000_0001

`endif

// >>> rtl/ctb_pkg.sv
// types of the core time base and timers block
package ctb_pkg;

    // ========================================================
    // synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } ctb_sync_t;

    // ========================================================
    // timer block state
    typedef struct packed {
        logic [63:0] tb;
        logic [31:0] rit;
        logic [31:0] reload;
        logic        ext_sel;
        logic        auto_rel;
        logic [1:0]  ptt_sel;
        logic [1:0]  wd_sel;
        logic [1:0]  rst_type;
        logic        wd_en;
        logic [2:0]  status;
        logic [2:0]  irq_en;
        logic        ext_prev;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        crit;
        logic        wd_rst;
        logic [1:0]  wd_type;
    } ctb_state_t;

endpackage

// >>> rtl/ctb_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ctb_sync
    import ctb_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // asynchronous input and clean level
    input  wire logic i_async,
    output logic      o_level
);

    ctb_sync_t st_reg;
    ctb_sync_t st_next;

    // ========================================================
    // shift chain; the level follows only when stages two and three agree
    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = i_async;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3)
        begin
            st_next.lvl = st_reg.s3;
        end
    end

    // ========================================================
    // state register
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_level = st_reg.lvl;

endmodule

// >>> rtl/ctb_timers.sv
// core time base with interval, tick and watchdog timers on apb
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "ctb_defs.svh"
module ctb_timers
    import ctb_pkg::*;
(
    // clock and reset
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    // apb slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic [31:0]      O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // external timer clock and debug freeze, asynchronous
    input  wire logic        I_TIMER_CLK,
    input  wire logic        I_DEBUG_FREEZE,
    // interrupts and watchdog reset
    output logic             O_IRQ,
    output logic             O_CRIT_IRQ,
    output logic             O_WD_RESET,
    output logic [1:0]       O_WD_RESET_TYPE
);

    ctb_state_t  st_reg;
    ctb_state_t  st_next;
    logic        ext_lvl;
    logic        frz_lvl;
    logic        tick;
    logic [63:0] tb_inc;
    logic        ptt_rise;
    logic        wd_rise;
    logic        rit_hit;
    logic        access;
    logic        fire;
    logic        wr_fire;
    logic        wr_tb;
    logic        wr_rit;
    logic [2:0]  clr_bits;
    logic [2:0]  events;
    logic [31:0] rd_data;
    logic        rd_ok;

    // ========================================================
    // synchronisers for the two asynchronous inputs
    ctb_sync u_sync_ext (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_async (I_TIMER_CLK),
        .o_level (ext_lvl)
    );

    ctb_sync u_sync_frz (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_async (I_DEBUG_FREEZE),
        .o_level (frz_lvl)
    );

    // ========================================================
    // time base bit picked by a two-bit select
    function automatic logic ptt_bit(input logic [63:0] v, input logic [1:0] s);
        logic b;
        b = 1'b0;
        unique case (s)
            2'h0: b = v[`CTB_PTT_BIT0];
            2'h1: b = v[`CTB_PTT_BIT1];
            2'h2: b = v[`CTB_PTT_BIT2];
            2'h3: b = v[`CTB_PTT_BIT3];
        endcase
        return b;
    endfunction

    function automatic logic wd_bit(input logic [63:0] v, input logic [1:0] s);
        logic b;
        b = 1'b0;
        unique case (s)
            2'h0: b = v[`CTB_WD_BIT0];
            2'h1: b = v[`CTB_WD_BIT1];
            2'h2: b = v[`CTB_WD_BIT2];
            2'h3: b = v[`CTB_WD_BIT3];
        endcase
        return b;
    endfunction

    // ========================================================
    // tick source and timer events
    // edges are judged on the increment itself, so a select change or a
    // software write to the time base never fakes an interval
    always_comb
    begin
        if (st_reg.ext_sel)
        begin
            tick = ext_lvl & ~st_reg.ext_prev & ~frz_lvl;
        end
        else
        begin
            tick = ~frz_lvl;
        end
        tb_inc   = st_reg.tb + `CTB_TB_ONE;
        ptt_rise = tick & ~ptt_bit(st_reg.tb, st_reg.ptt_sel)
                 & ptt_bit(tb_inc, st_reg.ptt_sel);
        wd_rise  = tick & ~wd_bit(st_reg.tb, st_reg.wd_sel)
                 & wd_bit(tb_inc, st_reg.wd_sel);
        rit_hit  = tick & (st_reg.rit == `CTB_W32_ONE);
    end

    // ========================================================
    // apb decode; one wait state, effect at the edge pready is sampled
    always_comb
    begin
        access   = I_PSEL & I_PENABLE;
        fire     = access & st_reg.pready;
        wr_fire  = fire & I_PWRITE;
        wr_tb    = wr_fire & ((I_PADDR == `CTB_OFF_TB_LO) | (I_PADDR == `CTB_OFF_TB_HI));
        wr_rit   = wr_fire & (I_PADDR == `CTB_OFF_RIT);
        clr_bits = (wr_fire && I_PADDR == `CTB_OFF_CLR) ? I_PWDATA[2:0] : `CTB_RST_EV;
        rd_ok    = 1'b1;
        rd_data  = `CTB_RST_W32;
        unique case (I_PADDR)
            `CTB_OFF_CTRL:
            begin
                rd_data[`CTB_CTRL_EXT]                       = st_reg.ext_sel;
                rd_data[`CTB_CTRL_AUTO]                      = st_reg.auto_rel;
                rd_data[`CTB_CTRL_FSEL_HI:`CTB_CTRL_FSEL_LO] = st_reg.ptt_sel;
                rd_data[`CTB_CTRL_WSEL_HI:`CTB_CTRL_WSEL_LO] = st_reg.wd_sel;
                rd_data[`CTB_CTRL_RTYP_HI:`CTB_CTRL_RTYP_LO] = st_reg.rst_type;
                rd_data[`CTB_CTRL_WEN]                       = st_reg.wd_en;
            end
            `CTB_OFF_TB_LO: rd_data = st_reg.tb[31:0];
            `CTB_OFF_TB_HI: rd_data = st_reg.tb[63:32];
            `CTB_OFF_RIT:   rd_data = st_reg.rit;
            `CTB_OFF_STAT:  rd_data[2:0] = st_reg.status;
            `CTB_OFF_CLR:   rd_data = `CTB_RST_W32;
            `CTB_OFF_IEN:   rd_data[2:0] = st_reg.irq_en;
            default:        rd_ok = 1'b0;
        endcase
    end

    // ========================================================
    // next state
    always_comb
    begin
        st_next          = st_reg;
        st_next.ext_prev = ext_lvl;

        // bus handshake
        if (access && !st_reg.pready)
        begin
            st_next.pready  = 1'b1;
            st_next.pslverr = ~rd_ok;
            st_next.prdata  = I_PWRITE ? `CTB_RST_W32 : rd_data;
        end
        else
        begin
            st_next.pready  = 1'b0;
            st_next.pslverr = 1'b0;
        end

        // time base; the wrap to zero carries no event of its own
        if (tick)
        begin
            st_next.tb = tb_inc;
        end
        if (wr_fire && I_PADDR == `CTB_OFF_TB_LO)
        begin
            st_next.tb[31:0] = I_PWDATA;
        end
        if (wr_fire && I_PADDR == `CTB_OFF_TB_HI)
        begin
            st_next.tb[63:32] = I_PWDATA;
        end

        // interval timer counts only on ticks and parks at zero
        if (rit_hit)
        begin
            st_next.rit = st_reg.auto_rel ? st_reg.reload : `CTB_RST_W32;
        end
        else if (tick && st_reg.rit != `CTB_RST_W32)
        begin
            st_next.rit = st_reg.rit - `CTB_W32_ONE;
        end
        if (wr_rit)
        begin
            st_next.rit    = I_PWDATA;
            st_next.reload = I_PWDATA;
        end

        // control and enable registers
        if (wr_fire && I_PADDR == `CTB_OFF_CTRL)
        begin
            st_next.ext_sel  = I_PWDATA[`CTB_CTRL_EXT];
            st_next.auto_rel = I_PWDATA[`CTB_CTRL_AUTO];
            st_next.ptt_sel  = I_PWDATA[`CTB_CTRL_FSEL_HI:`CTB_CTRL_FSEL_LO];
            st_next.wd_sel   = I_PWDATA[`CTB_CTRL_WSEL_HI:`CTB_CTRL_WSEL_LO];
            st_next.rst_type = I_PWDATA[`CTB_CTRL_RTYP_HI:`CTB_CTRL_RTYP_LO];
            st_next.wd_en    = I_PWDATA[`CTB_CTRL_WEN];
        end
        if (wr_fire && I_PADDR == `CTB_OFF_IEN)
        begin
            st_next.irq_en = I_PWDATA[2:0];
        end

        // sticky flags: a new event beats a clear in the same cycle
        events              = `CTB_RST_EV;
        events[`CTB_EV_RIT] = rit_hit;
        events[`CTB_EV_PTT] = ptt_rise;
        events[`CTB_EV_WD]  = wd_rise;
        st_next.status      = (st_reg.status & ~clr_bits) | events;

        // second expiry with the flag still up issues the reset
        st_next.wd_rst  = wd_rise & st_reg.wd_en & st_reg.status[`CTB_EV_WD];
        st_next.wd_type = st_reg.rst_type;

        // interrupt outputs follow the registered flags
        st_next.irq  = |(st_reg.status & st_reg.irq_en);
        st_next.crit = st_reg.status[`CTB_EV_WD] & st_reg.irq_en[`CTB_EV_WD];
    end

    // ========================================================
    // state register
    always_ff @(posedge I_CLK or posedge I_RESET)
    begin
        if (I_RESET)
        begin
            st_reg          <= '0;
            st_reg.tb       <= `CTB_RST_TB;
            st_reg.rit      <= `CTB_RST_W32;
            st_reg.reload   <= `CTB_RST_W32;
            st_reg.ptt_sel  <= `CTB_RST_SEL;
            st_reg.wd_sel   <= `CTB_RST_SEL;
            st_reg.status   <= `CTB_RST_EV;
            st_reg.irq_en   <= `CTB_RST_EV;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ========================================================
    // outputs straight from the state register
    assign O_PRDATA        = st_reg.prdata;
    assign O_PREADY        = st_reg.pready;
    assign O_PSLVERR       = st_reg.pslverr;
    assign O_IRQ           = st_reg.irq;
    assign O_CRIT_IRQ      = st_reg.crit;
    assign O_WD_RESET      = st_reg.wd_rst;
    assign O_WD_RESET_TYPE = st_reg.wd_type;

    // ========================================================
    // checks
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    // time base advances by one on each tick
    tb_count_a: assert property (tick && !wr_tb |=> st_reg.tb == $past(st_reg.tb) + 64'h1)
        else $error("time base did not advance on tick");

    // in external mode the time base does not move without an external edge
    ext_hold_a: assert property (st_reg.ext_sel && !tick && !wr_tb |=> $stable(st_reg.tb))
        else $error("time base moved without external edge");

    // wrap makes no tick or watchdog event
    wrap_quiet_a: assert property (tick && (&st_reg.tb) |-> !ptt_rise && !wd_rise)
        else $error("event raised on time base wrap");

    // interval timer holds between ticks
    rit_sync_a: assert property (!tick && !wr_rit |=> $stable(st_reg.rit))
        else $error("interval timer moved without tick");

    // interval timer decrements by one
    rit_dec_a: assert property (tick && !wr_rit && st_reg.rit > 32'h1
                                |=> st_reg.rit == $past(st_reg.rit) - 32'h1)
        else $error("interval timer did not decrement");

    // reaching zero without reload parks and flags
    rit_stop_a: assert property (rit_hit && !st_reg.auto_rel && !wr_rit
                                 |=> st_reg.rit == 32'h0 && st_reg.status[0]
                                 ##1 (!$past(st_reg.irq_en[0]) || st_reg.irq))
        else $error("interval timer zero handling wrong");

    // parked counter stays at zero
    rit_park_a: assert property (st_reg.rit == 32'h0 && !wr_rit |=> st_reg.rit == 32'h0)
        else $error("interval timer left zero on its own");

    // auto-reload restarts from last written value
    rit_reload_a: assert property (rit_hit && st_reg.auto_rel && !wr_rit
                                   |=> st_reg.rit == $past(st_reg.reload))
        else $error("interval timer reload wrong");

    // tick timer sets its flag
    ptt_flag_a: assert property (ptt_rise |=> st_reg.status[1])
        else $error("tick timer flag not set");

    // watchdog interval sets flag and critical output
    wd_flag_a: assert property (wd_rise |=> st_reg.status[2]
                                ##1 (!$past(st_reg.irq_en[2]) || O_CRIT_IRQ))
        else $error("watchdog flag or critical interrupt missing");

    // second uncleared expiry issues the selected reset
    wd_reset_a: assert property (wd_rise && st_reg.wd_en && st_reg.status[2]
                                 |=> O_WD_RESET && O_WD_RESET_TYPE == $past(st_reg.rst_type))
        else $error("watchdog reset not issued");

    // no reset without a standing flag
    wd_norst_a: assert property (!(wd_rise && st_reg.wd_en && st_reg.status[2]) |=> !O_WD_RESET)
        else $error("spurious watchdog reset");

    // freeze holds the time base
    frz_hold_a: assert property (frz_lvl && !wr_tb |=> $stable(st_reg.tb))
        else $error("time base moved during freeze");

    // software write loads counter and reload value
    rit_load_a: assert property (wr_rit |=> st_reg.rit == $past(I_PWDATA)
                                 && st_reg.reload == $past(I_PWDATA))
        else $error("interval timer load wrong");

endmodule

// >>> tb/ctb_far_model.sv
// far-side model: external timer clock source and watchdog reset monitor
`timescale 1ns/10ps
module ctb_far_model (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // bench control and block outputs
    input  wire logic       i_ext_run,
    input  wire logic       i_wd_reset,
    // timer clock and reset request count
    output logic            o_timer_clk,
    output logic [7:0]      o_wd_count
);
    logic [1:0] div_reg;

    // ============================================================
    // timer clock stands low between runs, so no stray edge sneaks in
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            div_reg     <= 2'h0;
            o_timer_clk <= 1'b0;
            o_wd_count  <= 8'h00;
        end
        else
        begin
            div_reg <= i_ext_run ? div_reg + 2'h1 : 2'h0;
            if (!i_ext_run)
                o_timer_clk <= 1'b0;
            else if (div_reg == 2'h3)
                o_timer_clk <= ~o_timer_clk; // slow clock, eight cycles a period
            if (i_wd_reset)
                o_wd_count <= o_wd_count + 8'h01; // system reset requests seen
        end
    end
endmodule

// >>> tb/tb_ctb_timers.sv
// self-checking bench for the time base and timers block
`timescale 1ns/10ps
`include "ctb_defs.svh"
module tb_ctb_timers;
    import ctb_pkg::*;
    logic        I_CLK, I_RESET, I_PSEL, I_PENABLE, I_PWRITE, I_DEBUG_FREEZE;
    logic [11:0] I_PADDR;
    logic [31:0] I_PWDATA, O_PRDATA, r, a, b;
    logic        O_PREADY, O_PSLVERR, O_IRQ, O_CRIT_IRQ, O_WD_RESET, tclk, ext_run, er;
    logic [1:0]  O_WD_RESET_TYPE;
    logic [7:0]  wd_count;
    int          n_fail, num_checks, bits[4], wbits[4];

    ctb_timers ctb_timers_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
        .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
        .I_TIMER_CLK(tclk), .I_DEBUG_FREEZE(I_DEBUG_FREEZE), .O_IRQ(O_IRQ),
        .O_CRIT_IRQ(O_CRIT_IRQ), .O_WD_RESET(O_WD_RESET), .O_WD_RESET_TYPE(O_WD_RESET_TYPE));
    ctb_far_model ctb_far_model_i (.i_clk(I_CLK), .i_reset(I_RESET), .i_ext_run(ext_run),
        .i_wd_reset(O_WD_RESET), .o_timer_clk(tclk), .o_wd_count(wd_count));

    // ============================================================
    // 40 MHz clock
    initial
    begin
        I_CLK = 1'b0;
        forever #12.5 I_CLK = ~I_CLK;
    end

    // ============================================================
    // verdict and checks
    task automatic end_sim();
    begin
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got %h want %h", $time, seen, exp);
        end
    end
    endtask

    // ============================================================
    // apb master: request held until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d,
                        output logic [31:0] rd_v, output logic err);
        int n;
    begin
        n = 0;
        @(posedge I_CLK);
        I_PSEL    <= 1'b1;
        I_PWRITE  <= w;
        I_PADDR   <= ad;
        I_PWDATA  <= d;
        I_PENABLE <= 1'b0;
        @(posedge I_CLK);
        I_PENABLE <= 1'b1;
        // pready is judged at the rising edge; the request stands until then
        do
        begin
            @(posedge I_CLK);
            n++;
        end
        while (O_PREADY !== 1'b1 && n < 50);
        if (n >= 50)
            chk(32'h0, 32'h1);
        rd_v = O_PRDATA;
        err  = O_PSLVERR;
        I_PSEL    <= 1'b0;
        I_PENABLE <= 1'b0;
    end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d);
        logic [31:0] t;
        logic        e;
    begin
        xfer(1'b1, ad, d, t, e);
    end
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] t;
        logic        x;
    begin
        xfer(1'b0, ad, 32'h0, t, x);
        chk(t & m, e);
    end
    endtask

    // freeze changes pass a synchroniser, so give them time to land
    task automatic frz(input logic v);
    begin
        @(posedge I_CLK);
        I_DEBUG_FREEZE <= v;
        repeat (8) @(posedge I_CLK);
    end
    endtask

    // ============================================================
    // watchdog against a hung run
    initial
    begin
        #(25 * 8000);
        n_fail++;
        end_sim();
    end

    // ============================================================
    // main sequence
    initial
    begin
        {I_PSEL, I_PENABLE, I_PWRITE, I_DEBUG_FREEZE, ext_run} = 5'h00;
        I_PADDR  = 12'h000;
        I_PWDATA = 32'h0000_0000;
        n_fail = 0;
        num_checks = 0;
        bits = '{`CTB_PTT_BIT0, `CTB_PTT_BIT1, `CTB_PTT_BIT2, `CTB_PTT_BIT3};
        wbits = '{`CTB_WD_BIT0, `CTB_WD_BIT1, `CTB_WD_BIT2, `CTB_WD_BIT3};
        I_RESET = 1'b1;
        repeat (16) @(posedge I_CLK);
        I_RESET <= 1'b0;
        // reset state and an unmapped address
        rd(`CTB_OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
        rd(`CTB_OFF_IEN, 32'hFFFF_FFFF, 32'h0);
        rd(`CTB_OFF_RIT, 32'hFFFF_FFFF, 32'h0);
        xfer(1'b0, 12'h01C, 32'h0, r, er);
        chk({r[31:1], er}, 32'h1);
        // one-shot interval count, masked then enabled interrupt
        wr(`CTB_OFF_RIT, 32'h3);
        repeat (8) @(posedge I_CLK);
        rd(`CTB_OFF_RIT, 32'hFFFF_FFFF, 32'h0);
        rd(`CTB_OFF_STAT, 32'h1, 32'h1);
        chk({31'h0, O_IRQ}, 32'h0);
        wr(`CTB_OFF_IEN, 32'h7);
        repeat (3) @(posedge I_CLK);
        chk({31'h0, O_IRQ}, 32'h1);
        wr(`CTB_OFF_CLR, 32'h7);
        rd(`CTB_OFF_STAT, 32'h1, 32'h0);
        // frozen load, then auto-reload keeps it running
        frz(1'b1);
        wr(`CTB_OFF_CTRL, 32'h2);
        wr(`CTB_OFF_RIT, 32'h5);
        rd(`CTB_OFF_RIT, 32'hFFFF_FFFF, 32'h5);
        xfer(1'b0, `CTB_OFF_TB_LO, 32'h0, a, er);
        rd(`CTB_OFF_TB_LO, 32'hFFFF_FFFF, a);
        frz(1'b0);
        repeat (30) @(posedge I_CLK);
        frz(1'b1);
        xfer(1'b0, `CTB_OFF_RIT, 32'h0, r, er);
        chk({31'h0, r >= 32'h1 && r <= 32'h5}, 32'h1);
        rd(`CTB_OFF_STAT, 32'h1, 32'h1);
        wr(`CTB_OFF_RIT, 32'h0);
        // tick timer: a rise of the chosen bit fires, a bit already high does not
        for (int s = 0; s < 4; s++)
            for (int k = 0; k < 2; k++)
            begin
                wr(`CTB_OFF_CTRL, 32'(s) << 2);
                wr(`CTB_OFF_TB_HI, 32'h0);
                wr(`CTB_OFF_TB_LO, (32'h1 << bits[s]) - 32'h4 + 32'(k * 8));
                wr(`CTB_OFF_CLR, 32'h7);
                frz(1'b0);
                frz(1'b1);
                rd(`CTB_OFF_STAT, 32'h2, k ? 32'h0 : 32'h2);
            end
        // watchdog period select: each choice watches its own bit
        for (int s = 0; s < 4; s++)
        begin
            wr(`CTB_OFF_CTRL, 32'(s) << 4);
            wr(`CTB_OFF_TB_LO, (32'h1 << wbits[s]) - 32'h4);
            wr(`CTB_OFF_CLR, 32'h7);
            frz(1'b0);
            frz(1'b1);
            rd(`CTB_OFF_STAT, 32'h4, 32'h4);
        end
        // wrap of the time base raises nothing
        wr(`CTB_OFF_CTRL, 32'h0);
        wr(`CTB_OFF_TB_HI, 32'hFFFF_FFFF);
        wr(`CTB_OFF_TB_LO, 32'hFFFF_FFFC);
        wr(`CTB_OFF_CLR, 32'h7);
        frz(1'b0);
        frz(1'b1);
        rd(`CTB_OFF_TB_HI, 32'hFFFF_FFFF, 32'h0);
        rd(`CTB_OFF_STAT, 32'h7, 32'h0);
        // watchdog: first expiry flags, second uncleared one resets
        wr(`CTB_OFF_CTRL, 32'h0000_0180);
        wr(`CTB_OFF_TB_HI, 32'h0);
        wr(`CTB_OFF_TB_LO, 32'h0001_FFF8);
        frz(1'b0);
        frz(1'b1);
        rd(`CTB_OFF_STAT, 32'h4, 32'h4);
        chk({31'h0, O_CRIT_IRQ}, 32'h1);
        chk({24'h0, wd_count}, 32'h0);
        wr(`CTB_OFF_TB_LO, 32'h0005_FFF8);
        frz(1'b0);
        frz(1'b1);
        chk({24'h0, wd_count}, 32'h1);
        chk({30'h0, O_WD_RESET_TYPE}, 32'h2);
        wr(`CTB_OFF_CLR, 32'h4);
        wr(`CTB_OFF_TB_LO, 32'h0009_FFF8);
        frz(1'b0);
        frz(1'b1);
        rd(`CTB_OFF_STAT, 32'h4, 32'h4);
        chk({24'h0, wd_count}, 32'h1);
        // external clock: no edges no count, then a slow run
        wr(`CTB_OFF_CTRL, 32'h1);
        frz(1'b0);
        xfer(1'b0, `CTB_OFF_TB_LO, 32'h0, a, er);
        repeat (20) @(posedge I_CLK);
        xfer(1'b0, `CTB_OFF_TB_LO, 32'h0, b, er);
        chk(b, a);
        ext_run <= 1'b1;
        repeat (40) @(posedge I_CLK);
        xfer(1'b0, `CTB_OFF_TB_LO, 32'h0, r, er);
        ext_run <= 1'b0;
        chk({31'h0, (r - b) >= 32'h3 && (r - b) <= 32'h8}, 32'h1);
        end_sim();
    end
endmodule
